/* File: shared/scp_cfg.svh */
// Constants of the serial configuration port: offsets, fields, defaults.
// Assumes inclusion by scp_port.sv only; holds definitions and no logic.
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
// -----------------------------------------------------------------
// Register offsets (5-bit serial address space)
// -----------------------------------------------------------------
`define SCP_ADR_PORT_CFG   5'h00
`define SCP_ADR_PLL_DIV    5'h03
`define SCP_ADR_PLL_CP     5'h04
`define SCP_ADR_I_FINE     5'h05
`define SCP_ADR_I_COARSE   5'h06
`define SCP_ADR_I_OFS_HI   5'h07
`define SCP_ADR_I_OFS_LO   5'h08
`define SCP_ADR_Q_FINE     5'h09
`define SCP_ADR_Q_COARSE   5'h0A
`define SCP_ADR_Q_OFS_HI   5'h0B
`define SCP_ADR_Q_OFS_LO   5'h0C
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define SCP_INS_RW_BIT     7
`define SCP_CFG_BIDIR_BIT  7
`define SCP_CFG_LSB_BIT    6
`define SCP_CFG_SWRST_BIT  5
`define SCP_PLL_EN_BIT     7
`define SCP_CP_MAN_BIT     6
`define SCP_OFS_DIR_BIT    7
// -----------------------------------------------------------------
// Implemented bit masks and reset values
// -----------------------------------------------------------------
`define SCP_MSK_PORT_CFG   8'hE0
`define SCP_MSK_PLL_DIV    8'h03
`define SCP_MSK_PLL_CP     8'hC7
`define SCP_MSK_FULL       8'hFF
`define SCP_MSK_COARSE     8'h0F
`define SCP_MSK_OFS_LO     8'h83
`define SCP_RST_REG        8'h00
// -----------------------------------------------------------------
// Timing: serial clock limit and system clock rate
// -----------------------------------------------------------------
`define SCP_SCLK_MAX_MHZ   15
`define SCP_CLK_MHZ        100
`define SCP_SCLK_MIN_CYC   ((`SCP_CLK_MHZ + `SCP_SCLK_MAX_MHZ - 1) / `SCP_SCLK_MAX_MHZ)
`endif

/* File: shared/scp_pkg.sv */
// Types of the serial configuration port: phases, register file, state.
// Assumes the constants header defines all numeric values.
package scp_pkg;
  // Port sequencing phases
  typedef enum logic [1:0] {SCP_INSTR, SCP_DATA, SCP_DONE} scp_phase_t;

  // Stored registers, reserved bits held at zero
  typedef struct packed {
    logic [7:0] r00, r03, r04, r05, r06, r07, r08, r09, r0a, r0b, r0c;
  } scp_regs_t;

  // Whole state of the port
  typedef struct packed {
    logic       sclk_s1, sclk_s2, sclk_d;
    logic       cs_s1, cs_s2;
    logic       din_s1, din_s2;
    scp_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic       rw;
    logic [1:0] bytes_left;
    logic [4:0] addr;
    logic [7:0] tx;
    logic       dout;
    scp_regs_t  regs;
  } scp_state_t;

  // Configuration seen by the converter core
  typedef struct packed {
    logic [1:0] pll_div;
    logic       pll_en;
    logic       cp_manual;
    logic [2:0] cp_current;
    logic [2:0] cp_bias_sel;
    logic [7:0] i_fine;
    logic [3:0] i_coarse;
    logic [9:0] i_offset;
    logic       i_offset_dir;
    logic [7:0] q_fine;
    logic [3:0] q_coarse;
    logic [9:0] q_offset;
    logic       q_offset_dir;
    logic       sdio_bidir;
    logic       lsb_first;
  } scp_cfg_out_t;
endpackage : scp_pkg

/* File: rtl/scp_port.sv */
// Serial configuration port with its register file, sampled on clk.
// Assumes serial pins are asynchronous to clk and clk is well above the
// serial clock rate; tristate wires are resolved outside from the enables.
//
// Contract
// [RULE1] Eight rising serial edges carry the instruction byte, data follows.
// [RULE2] Instruction bit 7 high means read, low means write.
// [RULE3] Instruction bits 6:5 give one to four data bytes.
// [RULE4] Bits 4:0 give the first address; later addresses made internally.
// [RULE5] Chip select high then low restarts at the instruction phase.
// [RULE6] A byte cut short by chip select writes nothing.
// [RULE7] Each write byte lands at once on its last bit.
// [RULE8] Input sampled on rising, output changed on falling serial edges.
// [RULE9] Host keeps the serial clock at or below 15 MHz.
// [RULE10] Both data pins float while chip select is high.
// [RULE11] Host holds chip select low for the whole cycle.
// [RULE12] Register 00h bit 7 makes the data pin bidirectional; default input.
// [RULE13] In bidirectional mode the separate output pin always floats.
// [RULE14] Register 00h bit 6 selects least significant bit first.
// [RULE15] Register 03h bits 1:0 give divide by one, two, four or eight.
// [RULE16] Register 04h bit 7 enables the PLL, default off.
// [RULE17] Register 04h bit 6 picks manual charge pump, default automatic.
// [RULE18] Register 04h bits 2:0 set manual bias, 50 to 800 microamps.
// [RULE19] Fine gain, eight bits, at 05h for I and 09h for Q.
// [RULE20] Coarse gain, four bits, at 06h for I and 0Ah for Q.
// [RULE21] Ten-bit offset from high byte and low two bits of each pair.
// [RULE22] Bit 7 of 08h or 0Ch sets offset direction.
// [RULE23] Multibyte address steps down in MSB-first, up in LSB-first.
// [RULE24] Software reset bit defaults all registers except 00h.
// [RULE25] Reads shift register contents out in the selected bit order.
`timescale 1ns/10ps
`include "scp_cfg.svh"

module scp_port (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          serial_clk,
  input  wire logic          chip_select_n,
  input  wire logic          serial_data_io_in,
  output logic               serial_data_io_out,
  output logic               serial_data_io_oe,
  output logic               serial_data_out_pin,
  output logic               serial_data_out_pin_oe,
  output scp_pkg::scp_cfg_out_t cfg
);
  import scp_pkg::*;

  // -----------------------------------------------------------------
  // Reset image of the register file
  // -----------------------------------------------------------------
  localparam scp_regs_t REG_DFLT = '{
    r00: `SCP_RST_REG, r03: `SCP_RST_REG, r04: `SCP_RST_REG,
    r05: `SCP_RST_REG, r06: `SCP_RST_REG, r07: `SCP_RST_REG,
    r08: `SCP_RST_REG, r09: `SCP_RST_REG, r0a: `SCP_RST_REG,
    r0b: `SCP_RST_REG, r0c: `SCP_RST_REG};

  scp_state_t s_r;
  scp_state_t s_nxt;
  logic       rise;
  logic       fall;
  logic       lsb;
  logic [7:0] byte_in;
  logic [4:0] addr_step;
  logic       ins_done;
  logic       byte_done;
  logic       wr_evt;
  logic       rd_act;

  // -----------------------------------------------------------------
  // Register read mux
  // -----------------------------------------------------------------
  // Unmapped addresses read zero so a multibyte read can walk past holes
  function automatic logic [7:0] rd_reg(input scp_regs_t r, input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `SCP_ADR_PORT_CFG: v = r.r00;
      `SCP_ADR_PLL_DIV:  v = r.r03;
      `SCP_ADR_PLL_CP:   v = r.r04;
      `SCP_ADR_I_FINE:   v = r.r05;
      `SCP_ADR_I_COARSE: v = r.r06;
      `SCP_ADR_I_OFS_HI: v = r.r07;
      `SCP_ADR_I_OFS_LO: v = r.r08;
      `SCP_ADR_Q_FINE:   v = r.r09;
      `SCP_ADR_Q_COARSE: v = r.r0a;
      `SCP_ADR_Q_OFS_HI: v = r.r0b;
      `SCP_ADR_Q_OFS_LO: v = r.r0c;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction : rd_reg

  // -----------------------------------------------------------------
  // Register write with field masks
  // -----------------------------------------------------------------
  function automatic scp_regs_t wr_reg(input scp_regs_t r, input logic [4:0] a,
                                       input logic [7:0] d);
    scp_regs_t w;
    w = r;
    case (a)
      `SCP_ADR_PORT_CFG: begin
        w = r;
        // Software reset defaults the rest; the port configuration takes the written byte
        if (d[`SCP_CFG_SWRST_BIT]) begin
          w = REG_DFLT; // [RULE24]
        end
        w.r00 = d & `SCP_MSK_PORT_CFG; // [RULE12] [RULE14]
      end
      `SCP_ADR_PLL_DIV:  w.r03 = d & `SCP_MSK_PLL_DIV; // [RULE15]
      `SCP_ADR_PLL_CP:   w.r04 = d & `SCP_MSK_PLL_CP; // [RULE16] [RULE17] [RULE18]
      `SCP_ADR_I_FINE:   w.r05 = d & `SCP_MSK_FULL; // [RULE19]
      `SCP_ADR_I_COARSE: w.r06 = d & `SCP_MSK_COARSE; // [RULE20]
      `SCP_ADR_I_OFS_HI: w.r07 = d & `SCP_MSK_FULL; // [RULE21]
      `SCP_ADR_I_OFS_LO: w.r08 = d & `SCP_MSK_OFS_LO; // [RULE21] [RULE22]
      `SCP_ADR_Q_FINE:   w.r09 = d & `SCP_MSK_FULL; // [RULE19]
      `SCP_ADR_Q_COARSE: w.r0a = d & `SCP_MSK_COARSE; // [RULE20]
      `SCP_ADR_Q_OFS_HI: w.r0b = d & `SCP_MSK_FULL; // [RULE21]
      `SCP_ADR_Q_OFS_LO: w.r0c = d & `SCP_MSK_OFS_LO; // [RULE21] [RULE22]
      default:           w = r;
    endcase
    return w;
  endfunction : wr_reg

  // -----------------------------------------------------------------
  // Edge detection and byte assembly
  // -----------------------------------------------------------------
  // Only the second sync stage and its delayed copy feed the detectors
  assign rise = s_r.sclk_s2 & ~s_r.sclk_d;
  assign fall = ~s_r.sclk_s2 & s_r.sclk_d;
  assign lsb  = s_r.regs.r00[`SCP_CFG_LSB_BIT];

  // Bit order is read live, so a config write mid-cycle acts at once
  assign byte_in = lsb ? {s_r.din_s2, s_r.shreg[7:1]} // [RULE14]
                       : {s_r.shreg[6:0], s_r.din_s2};

  // Address generator wraps in the 5-bit space
  assign addr_step = lsb ? s_r.addr + 5'h01 : s_r.addr - 5'h01; // [RULE23]

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    s_nxt     = s_r;
    ins_done  = 1'b0;
    byte_done = 1'b0;
    wr_evt    = 1'b0;

    // Two-stage synchronisers for every serial pin
    s_nxt.sclk_s1 = serial_clk;
    s_nxt.sclk_s2 = s_r.sclk_s1;
    s_nxt.sclk_d  = s_r.sclk_s2;
    s_nxt.cs_s1   = chip_select_n;
    s_nxt.cs_s2   = s_r.cs_s1;
    s_nxt.din_s1  = serial_data_io_in;
    s_nxt.din_s2  = s_r.din_s1;

    if (s_r.cs_s2) begin
      // Deselected: drop any partial byte and rearm
      s_nxt.phase   = SCP_INSTR; // [RULE5] [RULE6]
      s_nxt.bit_cnt = 3'd0;
      s_nxt.dout    = 1'b0;
    end else if (rise) begin
      // Sample input on the rising serial edge
      s_nxt.shreg   = byte_in; // [RULE8]
      s_nxt.bit_cnt = s_r.bit_cnt + 3'd1;
      if (s_r.bit_cnt == 3'd7) begin
        case (s_r.phase)
          SCP_INSTR: begin
            ins_done         = 1'b1; // [RULE1]
            s_nxt.rw         = byte_in[`SCP_INS_RW_BIT]; // [RULE2]
            s_nxt.bytes_left = byte_in[6:5]; // [RULE3]
            s_nxt.addr       = byte_in[4:0]; // [RULE4]
            s_nxt.tx         = rd_reg(s_r.regs, byte_in[4:0]); // [RULE25]
            s_nxt.phase      = SCP_DATA;
          end
          SCP_DATA: begin
            byte_done        = 1'b1;
            wr_evt           = ~s_r.rw; // [RULE7]
            s_nxt.addr       = addr_step; // [RULE4] [RULE23]
            s_nxt.tx         = rd_reg(s_r.regs, addr_step); // [RULE25]
            s_nxt.bytes_left = s_r.bytes_left - 2'd1;
            if (s_r.bytes_left == 2'd0) begin
              s_nxt.phase = SCP_DONE; // [RULE3]
            end
          end
          default: begin
            s_nxt.phase = SCP_DONE;
          end
        endcase
      end
    end else if (fall && s_r.phase == SCP_DATA && s_r.rw) begin
      // Launch read data on the falling edge so the host samples a rise
      s_nxt.dout = lsb ? s_r.tx[0] : s_r.tx[7]; // [RULE8] [RULE25]
      s_nxt.tx   = lsb ? {1'b0, s_r.tx[7:1]} : {s_r.tx[6:0], 1'b0};
    end

    // Writes land on the last bit, before the cycle ends
    if (wr_evt) begin
      s_nxt.regs = wr_reg(s_r.regs, s_r.addr, byte_in); // [RULE7]
    end
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r       <= '0;
      s_r.cs_s1 <= 1'b1;
      s_r.cs_s2 <= 1'b1;
      s_r.regs  <= REG_DFLT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Pin drivers
  // -----------------------------------------------------------------
  // Drive only during a read data phase with chip select low
  assign rd_act = ~s_r.cs_s2 & (s_r.phase == SCP_DATA) & s_r.rw; // [RULE10]
  assign serial_data_io_out     = s_r.dout;
  assign serial_data_out_pin    = s_r.dout;
  assign serial_data_io_oe      = rd_act & cfg.sdio_bidir; // [RULE12]
  assign serial_data_out_pin_oe = rd_act & ~cfg.sdio_bidir; // [RULE13]

  // -----------------------------------------------------------------
  // Configuration outputs to the converter core
  // -----------------------------------------------------------------
  // Automatic bias reuses the divider code; the core maps codes to currents
  always_comb begin
    cfg              = '0;
    cfg.sdio_bidir   = s_r.regs.r00[`SCP_CFG_BIDIR_BIT]; // [RULE12]
    cfg.lsb_first    = s_r.regs.r00[`SCP_CFG_LSB_BIT]; // [RULE14]
    cfg.pll_div      = s_r.regs.r03[1:0]; // [RULE15]
    cfg.pll_en       = s_r.regs.r04[`SCP_PLL_EN_BIT]; // [RULE16]
    cfg.cp_manual    = s_r.regs.r04[`SCP_CP_MAN_BIT];
    cfg.cp_current   = s_r.regs.r04[2:0]; // [RULE18]
    cfg.cp_bias_sel  = cfg.cp_manual ? cfg.cp_current
                                     : {1'b0, cfg.pll_div}; // [RULE17]
    cfg.i_fine       = s_r.regs.r05; // [RULE19]
    cfg.i_coarse     = s_r.regs.r06[3:0]; // [RULE20]
    cfg.i_offset     = {s_r.regs.r07, s_r.regs.r08[1:0]}; // [RULE21]
    cfg.i_offset_dir = s_r.regs.r08[`SCP_OFS_DIR_BIT]; // [RULE22]
    cfg.q_fine       = s_r.regs.r09; // [RULE19]
    cfg.q_coarse     = s_r.regs.r0a[3:0]; // [RULE20]
    cfg.q_offset     = {s_r.regs.r0b, s_r.regs.r0c[1:0]}; // [RULE21]
    cfg.q_offset_dir = s_r.regs.r0c[`SCP_OFS_DIR_BIT]; // [RULE22]
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  property p_instr_to_data;
    @(posedge clk) disable iff (rst)
      (~s_r.cs_s2 && rise && s_r.phase == SCP_INSTR && s_r.bit_cnt == 3'd7)
      |=> (s_r.phase == SCP_DATA && s_r.bit_cnt == 3'd0);
  endproperty
  a_instr_to_data: assert property (p_instr_to_data) // [RULE1]
    else $error("instruction byte did not open data phase");

  property p_rw_decode;
    @(posedge clk) disable iff (rst)
      ins_done |=> (s_r.rw == $past(byte_in[7]));
  endproperty
  a_rw_decode: assert property (p_rw_decode) // [RULE2]
    else $error("direction flag not taken from bit 7");

  property p_count_decode;
    @(posedge clk) disable iff (rst)
      ins_done |=> (s_r.bytes_left == $past(byte_in[6:5]));
  endproperty
  a_count_decode: assert property (p_count_decode) // [RULE3]
    else $error("byte count not taken from bits 6:5");

  property p_addr_decode;
    @(posedge clk) disable iff (rst)
      ins_done |=> (s_r.addr == $past(byte_in[4:0]));
  endproperty
  a_addr_decode: assert property (p_addr_decode) // [RULE4]
    else $error("start address not taken from bits 4:0");

  property p_restart;
    @(posedge clk) disable iff (rst)
      s_r.cs_s2 |=> (s_r.phase == SCP_INSTR && s_r.bit_cnt == 3'd0);
  endproperty
  a_restart: assert property (p_restart) // [RULE5]
    else $error("chip select high did not rearm the port");

  property p_no_partial_write;
    @(posedge clk) disable iff (rst)
      s_r.cs_s2 |=> $stable(s_r.regs);
  endproperty
  a_no_partial_write: assert property (p_no_partial_write) // [RULE6]
    else $error("register changed while deselected");

  property p_write_now;
    @(posedge clk) disable iff (rst)
      (wr_evt && s_r.addr == `SCP_ADR_I_FINE) |=> (s_r.regs.r05 == $past(byte_in));
  endproperty
  a_write_now: assert property (p_write_now) // [RULE7]
    else $error("write byte not stored on its last bit");

  property p_out_on_fall;
    @(posedge clk) disable iff (rst)
      ($changed(s_r.dout) && ~s_r.cs_s2) |-> $past(fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) // [RULE8]
    else $error("output data changed away from a falling edge");

  property p_float_deselected;
    @(posedge clk) disable iff (rst)
      s_r.cs_s2 |-> (!serial_data_io_oe && !serial_data_out_pin_oe);
  endproperty
  a_float_deselected: assert property (p_float_deselected) // [RULE10]
    else $error("data pin driven while deselected");

  property p_sdio_input_only;
    @(posedge clk) disable iff (rst)
      !cfg.sdio_bidir |-> !serial_data_io_oe;
  endproperty
  a_sdio_input_only: assert property (p_sdio_input_only) // [RULE12]
    else $error("data pin driven in input-only mode");

  property p_sdo_float_bidir;
    @(posedge clk) disable iff (rst)
      cfg.sdio_bidir |-> !serial_data_out_pin_oe;
  endproperty
  a_sdo_float_bidir: assert property (p_sdo_float_bidir) // [RULE13]
    else $error("separate output driven in bidirectional mode");

  property p_addr_step;
    @(posedge clk) disable iff (rst)
      (byte_done && !lsb) |=> (s_r.addr == $past(s_r.addr) - 5'h01);
  endproperty
  a_addr_step: assert property (p_addr_step) // [RULE23]
    else $error("address did not step down in MSB-first mode");

  property p_soft_reset;
    @(posedge clk) disable iff (rst)
      (wr_evt && s_r.addr == `SCP_ADR_PORT_CFG && byte_in[`SCP_CFG_SWRST_BIT])
      |=> (s_r.regs.r05 == `SCP_RST_REG && s_r.regs.r0c == `SCP_RST_REG);
  endproperty
  a_soft_reset: assert property (p_soft_reset) // [RULE24]
    else $error("software reset left a register set");

  property p_addr_step_up;
    @(posedge clk) disable iff (rst)
      (byte_done && lsb) |=> (s_r.addr == $past(s_r.addr) + 5'h01);
  endproperty
  a_addr_step_up: assert property (p_addr_step_up) // [RULE23]
    else $error("address did not step up in LSB-first mode");

  // The top bit goes first, so a swapped shift direction shows at once
  property p_read_msb_first;
    @(posedge clk) disable iff (rst)
      (fall && !s_r.cs_s2 && s_r.phase == SCP_DATA && s_r.rw && !lsb)
      |=> (s_r.dout == $past(s_r.tx[7]));
  endproperty
  a_read_msb_first: assert property (p_read_msb_first) // [RULE25]
    else $error("read bit not taken from the top of the byte");

  property p_done_no_write;
    @(posedge clk) disable iff (rst)
      (s_r.phase == SCP_DONE) |-> !wr_evt;
  endproperty
  a_done_no_write: assert property (p_done_no_write) // [RULE3]
    else $error("write after the last counted byte");

  property p_write_no_drive;
    @(posedge clk) disable iff (rst)
      !s_r.rw |-> (!serial_data_io_oe && !serial_data_out_pin_oe);
  endproperty
  a_write_no_drive: assert property (p_write_no_drive) // [RULE2]
    else $error("data pin driven during a write");

endmodule : scp_port

/* File: verif/scp_host_model.sv */
// Host side model: a serial master that drives clock, select and data.
// Assumes the bench resolves the shared data wires and feeds them back.
`timescale 1ns/10ps

module scp_host_model #(
  parameter int H = 6
) (
  input  wire logic clk,
  output logic      serial_clk,
  output logic      chip_select_n,
  output logic      mosi,
  output logic      mosi_oe,
  input  wire logic miso_io,
  input  wire logic miso_out
);
  // -----------------------------------------------------------------
  // Idle levels: clock stands low outside frames, select high
  // -----------------------------------------------------------------
  initial begin
    serial_clk    = 1'b0;
    chip_select_n = 1'b1;
    mosi          = 1'b0;
    mosi_oe       = 1'b0;
  end

  // -----------------------------------------------------------------
  // One frame; cut stops after that many bits to model an abort
  // -----------------------------------------------------------------
  // Half period of H clk cycles keeps the serial rate below 15 MHz
  task automatic xfer(input logic [7:0] ins, input logic lsb, input logic bidir,
                      input logic [31:0] wd, input int cut, output logic [31:0] rd);
    int       nb;
    int       j;
    int       k;
    int       pos;
    logic [7:0] b;
    nb = int'(ins[6:5]) + 1;
    rd = '0;
    @(posedge clk) chip_select_n <= 1'b0; // Held low for the whole frame
    repeat (H) @(posedge clk);
    // Instruction byte first, then data bytes, same bit order
    for (j = 0; j < 8 * (nb + 1) && j != cut; j++) begin
      k   = j / 8;
      pos = lsb ? (j % 8) : (7 - (j % 8));
      b   = (k == 0) ? ins : wd[8*(k-1)+:8];
      // Data changes on the fall, host lets go of the line in read data
      @(posedge clk) begin
        serial_clk <= 1'b0;
        mosi       <= b[pos];
        mosi_oe    <= !(ins[7] && k > 0);
      end
      repeat (H - 1) @(posedge clk);
      // Read data taken at the rise
      @(posedge clk) begin
        serial_clk <= 1'b1;
        // Line stays driven through the last instruction rise, let go at the next fall
        if (k > 0) rd[8*(k-1)+pos] = bidir ? miso_io : miso_out;
      end
      repeat (H - 1) @(posedge clk);
    end
    @(posedge clk) begin
      chip_select_n <= 1'b1;
      serial_clk    <= 1'b0;
      mosi_oe       <= 1'b0;
    end
    repeat (2 * H) @(posedge clk);
  endtask : xfer
endmodule : scp_host_model

/* File: verif/scp_port_tb.sv */
// Self-checking bench of the serial configuration port.
// Assumes the host model drives frames; bench resolves the data wires.
`timescale 1ns/10ps

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %0h got %0h", n, e, g); num_errors++; end end

module scp_port_tb;
  import scp_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 sclk, csn, mosi, mosi_oe, io_out, io_oe, so, so_oe;
  logic                 io_hold = 1'b0;
  logic                 so_hold = 1'b0;
  logic                 io_seen = 1'b0;
  logic                 so_seen = 1'b0;
  logic                 lsb_m = 1'b0;
  logic                 bidir_m = 1'b0;
  logic [31:0]          rdat;
  scp_cfg_out_t         cfg;
  int                   num_errors = 0;
  int                   samples_checked = 0;
  int                   cyc = 0;
  wire logic            io_line = io_oe ? io_out : (mosi_oe ? mosi : ~io_hold);
  wire logic            so_line = so_oe ? so : ~so_hold;

  always #5 clk = ~clk;

  // -----------------------------------------------------------------
  // Released lines toggle so a stale value is never mistaken for data
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    io_hold <= io_line;
    so_hold <= so_line;
    if (io_oe) io_seen <= 1'b1;
    if (so_oe) so_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      end_sim();
    end
  end

  scp_port dut (.clk(clk), .rst(rst), .serial_clk(sclk), .chip_select_n(csn),
    .serial_data_io_in(io_line), .serial_data_io_out(io_out), .serial_data_io_oe(io_oe),
    .serial_data_out_pin(so), .serial_data_out_pin_oe(so_oe), .cfg(cfg));

  scp_host_model #(.H(6)) host (.clk(clk), .serial_clk(sclk), .chip_select_n(csn),
    .mosi(mosi), .mosi_oe(mosi_oe), .miso_io(io_line), .miso_out(so_line));

  // -----------------------------------------------------------------
  // Shared helpers
  // -----------------------------------------------------------------
  task automatic go(input logic [7:0] ins, input logic [31:0] wd, input int cut = 99);
    io_seen = 1'b0;
    so_seen = 1'b0;
    host.xfer(ins, lsb_m, bidir_m, wd, cut, rdat);
  endtask : go

  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    `CHK("cfg", '0, cfg)
    go(8'h80, 0);
    `CHK("rd00", 8'h00, rdat[7:0])
    go(8'h81, 0);
    `CHK("rd01", 8'h00, rdat[7:0])
    `CHK("io_oe", 1'b0, io_seen)
    `CHK("idle oe", 2'b00, {io_oe, so_oe})
  endtask : t_reset

  task automatic t_gains();
    go(8'h05, 32'hA5);
    `CHK("i_fine", 8'hA5, cfg.i_fine)
    go(8'h6C, 32'h3CFF5A83);
    `CHK("q_fine", 8'h3C, cfg.q_fine)
    `CHK("q_coarse", 4'hF, cfg.q_coarse)
    `CHK("q_offset", {8'h5A, 2'b11}, cfg.q_offset)
    `CHK("q_dir", 1'b1, cfg.q_offset_dir)
    go(8'hAC, 0);
    `CHK("rd0C0B", 16'h5A83, rdat[15:0])
    `CHK("so used", 2'b01, {io_seen, so_seen})
    go(8'h28, 32'h96FD);
    `CHK("i_offset", {8'h96, 2'b01}, cfg.i_offset)
    `CHK("i_dir", 1'b1, cfg.i_offset_dir)
    go(8'h88, 0);
    `CHK("rd08 mask", 8'h81, rdat[7:0])
  endtask : t_gains

  task automatic t_pll();
    int d;
    for (d = 0; d < 4; d++) begin
      go(8'h24, {16'h0, 6'h0, d[1:0], 8'h80});
      `CHK("pll_div", d[1:0], cfg.pll_div)
      `CHK("pll_en", 1'b1, cfg.pll_en)
      `CHK("auto bias", {1'b0, d[1:0]}, cfg.cp_bias_sel)
    end
    for (d = 0; d < 5; d++) begin
      go(8'h04, {24'h0, 5'b11000, d[2:0]});
      `CHK("cp_man", 1'b1, cfg.cp_manual)
      `CHK("man bias", d[2:0], cfg.cp_bias_sel)
      `CHK("cp_cur", d[2:0], cfg.cp_current)
    end
  endtask : t_pll

  task automatic t_abort();
    go(8'h05, 32'h11, 5);
    `CHK("cut instr", 8'hA5, cfg.i_fine)
    go(8'h26, 32'h3307, 19);
    `CHK("first lands", 4'h7, cfg.i_coarse)
    `CHK("cut data", 8'hA5, cfg.i_fine)
    go(8'h85, 0);
    `CHK("restart", 8'hA5, rdat[7:0])
  endtask : t_abort

  task automatic t_lsb();
    go(8'h00, 32'h40);
    lsb_m = 1'b1;
    `CHK("lsb", 1'b1, cfg.lsb_first)
    go(8'h25, 32'h0211);
    `CHK("lsb 05", 8'h11, cfg.i_fine)
    `CHK("lsb 06", 4'h2, cfg.i_coarse)
    go(8'h86, 0);
    `CHK("lsb rd", 8'h02, rdat[7:0])
  endtask : t_lsb

  task automatic t_bidir();
    go(8'h00, 32'hC0);
    bidir_m = 1'b1;
    `CHK("bidir", 1'b1, cfg.sdio_bidir)
    go(8'h85, 0);
    `CHK("bidir rd", 8'h11, rdat[7:0])
    `CHK("so quiet", 2'b10, {io_seen, so_seen})
  endtask : t_bidir

  task automatic t_swrst();
    go(8'h00, 32'h20);
    lsb_m   = 1'b0;
    bidir_m = 1'b0;
    `CHK("others", 8'h00, cfg.i_fine)
    `CHK("pll", 1'b0, cfg.pll_en)
    go(8'h80, 0);
    `CHK("keep 00", 8'h20, rdat[7:0])
  endtask : t_swrst

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_gains();
    t_pll();
    t_abort();
    t_lsb();
    t_bidir();
    t_swrst();
    end_sim();
  end
endmodule : scp_port_tb
